// File: design/nst_self_test.v
// self-test sequencer and error indicators with an axi4-lite slave
// Functional notes
// - any test mode is offline; no cyclic data-link exchange meanwhile.
// - test-ok indicator blinks while a test runs.
// - pass blinks test-ok 20 times, no error blink; failure blinks error.
// - ring self-loopback: forward path broken lights time error.
// - ring self-loopback: reverse path broken lights data error.
// - ring self-loopback: defective cable lights crc, overrun, abort both sides.
// - ring self-loopback: hardware fault or link lost lights underrun.
// - coax self-loopback: time; crc/over/abort; data plus underrun cases.
// - internal loopback hardware fault lights all nine error indicators.
// - hardware test: rom crc, ram overrun, timer or interrupt abort.
// - hardware test on ring: forward break time, reverse break data.
// - coax boards may also light conflict or parameter error on failure.
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`include "nst_defines.vh"
module nst_self_test #(
	parameter TEST_CYCLES = `NST_TEST_MS * `NST_CLK_KHZ,
	parameter BLINK_HALF = `NST_BLINK_HALF_MS * `NST_CLK_KHZ,
	parameter PASS_BLINKS = `NST_PASS_BLINKS
) (
	input wire aclk,
	input wire aresetn,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire medium_coax_pin,
	input wire fwd_path_ok,
	input wire rev_path_ok,
	input wire rx_defective,
	input wire link_lost,
	input wire hw_fault,
	input wire rom_fail,
	input wire ram_fail,
	input wire timer_irq_fail,
	input wire station_conflict,
	input wire param_fault,
	output wire link_enable,
	output wire test_ok_indicator,
	output wire error_indicator,
	output wire [`NST_ERR_W-1:0] err_indicators,
	output wire station_conflict_indicator,
	output wire parameter_error_indicator,
	output wire irq
);
	localparam S_IDLE = 5'h01;
	localparam S_RUN = 5'h02;
	localparam S_PASS = 5'h04;
	localparam S_FAIL = 5'h08;
	localparam S_DONE = 5'h10;

	// maps live fault inputs of one cycle onto indicator bits
	function [`NST_ERR_W-1:0] err_map;
		input [1:0] mode;
		input coax;
		input fwd_ok, rev_ok, defect, lost, hwf, rom, ram, tmr;
		reg [`NST_ERR_W-1:0] e;
		begin
			e = {`NST_ERR_W{1'b0}};
			case (mode)
			`NST_MODE_SELF: begin
				e[`NST_ERR_TIME] = ~fwd_ok;
				e[`NST_ERR_CRC_F] = defect;
				e[`NST_ERR_OVER_F] = defect;
				e[`NST_ERR_ABORT_F] = defect;
				e[`NST_ERR_CRC_R] = defect;
				e[`NST_ERR_OVER_R] = defect;
				e[`NST_ERR_ABORT_R] = defect;
				e[`NST_ERR_UNDER] = hwf | lost;
				if (coax)
					e[`NST_ERR_DATA] = hwf | lost;
				else
					e[`NST_ERR_DATA] = ~rev_ok;
			end
			`NST_MODE_INTERNAL: begin
				e = {`NST_ERR_W{hwf}};
			end
			`NST_MODE_HW: begin
				e[`NST_ERR_CRC_F] = rom;
				e[`NST_ERR_OVER_F] = ram;
				e[`NST_ERR_ABORT_F] = tmr;
				if (!coax) begin
					e[`NST_ERR_TIME] = ~fwd_ok;
					e[`NST_ERR_DATA] = ~rev_ok;
				end
			end
			default: begin
				e = {`NST_ERR_W{1'b0}};
			end
			endcase
			err_map = e;
		end
	endfunction

	reg coax_s1_q, coax_s2_q, coax_q, strap_done_q;
	reg aw_q, w_q, bvalid_q, rvalid_q;
	reg [3:0] awaddr_q;
	reg aw_bad_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg [1:0] bresp_q, rresp_q;
	reg [31:0] rdata_q;
	reg [1:0] mode_q;
	reg [`NST_IRQ_W-1:0] irq_stat_q, irq_mask_q;
	reg [4:0] state_q;
	reg [31:0] run_cnt_q;
	reg [`NST_ERR_W-1:0] err_q;
	reg conflict_q, param_q;
	wire aw_hs, w_hs, ar_hs, wr_fire;
	wire [3:0] wa;
	wire wa_bad;
	wire [31:0] wd;
	wire [3:0] ws;
	wire ctrl_wr, start_req, mode_change, clear_res;
	wire [1:0] new_mode;
	wire [`NST_ERR_W-1:0] err_now;
	wire run_end, fail_now;
	wire pass_busy;
	wire [`NST_ST_TOP:0] status_w;
	reg [31:0] rd_mux;
	reg [`NST_IRQ_W-1:0] irq_set;

	// strap sync: keeps sampling through reset so it is full at release
	always @(posedge aclk) begin
		coax_s1_q <= medium_coax_pin;
		coax_s2_q <= coax_s1_q;
	end

	// strap caught once after reset release
	always @(posedge aclk) begin
		if (!aresetn) begin
			coax_q <= 1'b0;
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			coax_q <= coax_s2_q;
			strap_done_q <= 1'b1;
		end
	end

	// write channels taken in either order, response after both
	assign s_axi_awready = ~aw_q & ~bvalid_q;
	assign s_axi_wready = ~w_q & ~bvalid_q;
	assign aw_hs = s_axi_awvalid & s_axi_awready;
	assign w_hs = s_axi_wvalid & s_axi_wready;
	assign wr_fire = (aw_q | aw_hs) & (w_q | w_hs);
	assign wa = aw_q ? awaddr_q : s_axi_awaddr[3:0];
	assign wa_bad = aw_q ? aw_bad_q :
		((s_axi_awaddr[31:4] != 28'h0) || (s_axi_awaddr[1:0] != 2'h0));
	assign wd = w_q ? wdata_q : s_axi_wdata;
	assign ws = w_q ? wstrb_q : s_axi_wstrb;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 4'h0;
			aw_bad_q <= 1'b0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= `NST_RESP_OKAY;
		end else begin
			if (wr_fire) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= (wa_bad || wa == `NST_ADDR_STATUS) ?
					`NST_RESP_SLVERR : `NST_RESP_OKAY;
			end else begin
				if (aw_hs) begin
					aw_q <= 1'b1;
					awaddr_q <= s_axi_awaddr[3:0];
					aw_bad_q <= wa_bad;
				end
				if (w_hs) begin
					w_q <= 1'b1;
					wdata_q <= s_axi_wdata;
					wstrb_q <= s_axi_wstrb;
				end
				if (s_axi_bready)
					bvalid_q <= 1'b0;
			end
		end
	end

	// control register writes: mode select and start pulse
	assign ctrl_wr = wr_fire & ~wa_bad & (wa == `NST_ADDR_CTRL) & ws[0];
	assign new_mode = wd[`NST_CTRL_MODE_HI:`NST_CTRL_MODE_LO];
	assign mode_change = ctrl_wr & (new_mode != mode_q);
	assign start_req = ctrl_wr & wd[`NST_CTRL_START] &
		(new_mode != `NST_MODE_ONLINE);
	assign clear_res = mode_change | (start_req & (state_q != S_RUN));

	always @(posedge aclk) begin
		if (!aresetn) begin
			mode_q <= `NST_MODE_ONLINE;
			irq_mask_q <= {`NST_IRQ_W{1'b0}};
		end else begin
			if (ctrl_wr)
				mode_q <= new_mode;
			if (wr_fire && !wa_bad && wa == `NST_ADDR_IRQ_MASK && ws[0])
				irq_mask_q <= wd[`NST_IRQ_W-1:0];
		end
	end

	// offline in every test mode
	assign link_enable = (mode_q == `NST_MODE_ONLINE);

	// test run: count the window and gather faults
	assign err_now = err_map(mode_q, coax_q, fwd_path_ok, rev_path_ok,
		rx_defective, link_lost, hw_fault, rom_fail, ram_fail,
		timer_irq_fail);
	assign run_end = (state_q == S_RUN) && (run_cnt_q == TEST_CYCLES - 1);
	assign fail_now = (err_q != {`NST_ERR_W{1'b0}}) ||
		(err_now != {`NST_ERR_W{1'b0}});

	always @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= S_IDLE;
			run_cnt_q <= 32'h0;
			err_q <= {`NST_ERR_W{1'b0}};
			conflict_q <= 1'b0;
			param_q <= 1'b0;
		end else if (clear_res) begin
			// new mode clears the held result
			state_q <= start_req ? S_RUN : S_IDLE;
			run_cnt_q <= 32'h0;
			err_q <= {`NST_ERR_W{1'b0}};
			conflict_q <= 1'b0;
			param_q <= 1'b0;
		end else begin
			case (state_q)
			S_IDLE: begin
				state_q <= S_IDLE;
			end
			S_RUN: begin
				run_cnt_q <= run_cnt_q + 32'h1;
				err_q <= err_q | err_now;
				if (coax_q) begin
					conflict_q <= conflict_q | station_conflict;
					param_q <= param_q | param_fault;
				end
				if (run_end)
					state_q <= fail_now ? S_FAIL : S_PASS;
			end
			S_PASS: begin
				if (!pass_busy)
					state_q <= S_DONE;
			end
			S_FAIL: begin
				state_q <= S_FAIL;
			end
			S_DONE: begin
				state_q <= S_DONE;
			end
			default: begin
				state_q <= S_IDLE;
			end
			endcase
		end
	end

	assign err_indicators = (state_q == S_FAIL) ? err_q :
		{`NST_ERR_W{1'b0}};
	assign station_conflict_indicator = (state_q == S_FAIL) & conflict_q;
	assign parameter_error_indicator = (state_q == S_FAIL) & param_q;

	// test-ok: continuous while running, counted burst on pass
	nst_blinker #(
		.HALF_CYCLES(BLINK_HALF),
		.BURST(PASS_BLINKS)
	) u_pass_blink (
		.aclk(aclk),
		.aresetn(aresetn),
		.run((state_q == S_RUN) & ~run_end & ~clear_res),
		.burst_start(run_end & ~fail_now & ~clear_res),
		.led(test_ok_indicator),
		.busy(pass_busy)
	);

	// error: blinks only after a failed run
	nst_blinker #(
		.HALF_CYCLES(BLINK_HALF),
		.BURST(PASS_BLINKS)
	) u_err_blink (
		.aclk(aclk),
		.aresetn(aresetn),
		.run((state_q == S_FAIL) & ~clear_res),
		.burst_start(1'b0),
		.led(error_indicator),
		.busy()
	);

	// sticky events, set wins over the read clear
	always @* begin
		irq_set = {`NST_IRQ_W{1'b0}};
		irq_set[`NST_IRQ_PASS] = (state_q == S_PASS) & ~pass_busy;
		irq_set[`NST_IRQ_FAIL] = run_end & fail_now;
	end

	assign status_w = {coax_q, param_q, conflict_q, state_q == S_FAIL,
		state_q == S_RUN, error_indicator, test_ok_indicator,
		err_indicators};

	// read channel: one cycle to rvalid, unmapped gives slverr
	assign s_axi_arready = ~rvalid_q;
	assign ar_hs = s_axi_arvalid & s_axi_arready;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always @* begin
		rd_mux = 32'h0;
		case (s_axi_araddr[3:0])
		`NST_ADDR_CTRL: rd_mux[`NST_CTRL_MODE_HI:0] = mode_q;
		`NST_ADDR_STATUS: rd_mux[`NST_ST_TOP:0] = status_w;
		`NST_ADDR_IRQ_STAT: rd_mux[`NST_IRQ_W-1:0] = irq_stat_q;
		`NST_ADDR_IRQ_MASK: rd_mux[`NST_IRQ_W-1:0] = irq_mask_q;
		default: rd_mux = 32'h0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= `NST_RESP_OKAY;
			irq_stat_q <= {`NST_IRQ_W{1'b0}};
		end else begin
			if (ar_hs) begin
				rvalid_q <= 1'b1;
				if (s_axi_araddr[31:4] != 28'h0 ||
					s_axi_araddr[1:0] != 2'h0) begin
					rdata_q <= 32'h0;
					rresp_q <= `NST_RESP_SLVERR;
				end else begin
					rdata_q <= rd_mux;
					rresp_q <= `NST_RESP_OKAY;
				end
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
			if (ar_hs && s_axi_araddr == {28'h0, `NST_ADDR_IRQ_STAT})
				irq_stat_q <= irq_set;
			else
				irq_stat_q <= irq_stat_q | irq_set;
		end
	end

	assign irq = |(irq_stat_q & irq_mask_q);
endmodule

// File: design/nst_defines.vh
// shared constants for the network board self-test block
`ifndef NST_DEFINES_VH
`define NST_DEFINES_VH

// register byte offsets (low nibble of the address)
`define NST_ADDR_CTRL 4'h0
`define NST_ADDR_STATUS 4'h4
`define NST_ADDR_IRQ_STAT 4'h8
`define NST_ADDR_IRQ_MASK 4'hC

// control register fields
`define NST_CTRL_MODE_HI 1
`define NST_CTRL_MODE_LO 0
`define NST_CTRL_START 4

// test mode codes
`define NST_MODE_ONLINE 2'h0
`define NST_MODE_SELF 2'h1
`define NST_MODE_INTERNAL 2'h2
`define NST_MODE_HW 2'h3

// error indicator vector positions
`define NST_ERR_W 9
`define NST_ERR_CRC_F 0
`define NST_ERR_OVER_F 1
`define NST_ERR_ABORT_F 2
`define NST_ERR_CRC_R 3
`define NST_ERR_OVER_R 4
`define NST_ERR_ABORT_R 5
`define NST_ERR_TIME 6
`define NST_ERR_DATA 7
`define NST_ERR_UNDER 8

// status register fields above the error vector
`define NST_ST_PASS_LED 9
`define NST_ST_ERR_LED 10
`define NST_ST_RUNNING 11
`define NST_ST_FAILED 12
`define NST_ST_CONFLICT 13
`define NST_ST_PARAM 14
`define NST_ST_COAX 15
`define NST_ST_TOP 15

// interrupt status bits
`define NST_IRQ_W 2
`define NST_IRQ_PASS 0
`define NST_IRQ_FAIL 1

// axi response codes
`define NST_RESP_OKAY 2'h0
`define NST_RESP_SLVERR 2'h2

// timing
`define NST_CLK_KHZ 125000
`define NST_BLINK_HALF_MS 250
`define NST_TEST_MS 1000
`define NST_PASS_BLINKS 20

`endif

// File: design/nst_blinker.v
// indicator blinker with continuous and counted burst modes
`timescale 1ns/100ps
module nst_blinker #(
	parameter HALF_CYCLES = 31250000,
	parameter BURST = 20
) (
	input wire aclk,
	input wire aresetn,
	input wire run,
	input wire burst_start,
	output wire led,
	output wire busy
);
	reg [31:0] tick_q;
	reg led_q;
	reg [7:0] left_q;
	reg burst_q;
	wire active;
	wire wrap;

	assign active = run | burst_q;
	assign wrap = (tick_q == HALF_CYCLES - 1);
	assign led = led_q;
	assign busy = burst_q;

	// half-period timer, led toggle and burst count
	always @(posedge aclk) begin
		if (!aresetn) begin
			tick_q <= 32'h0;
			led_q <= 1'b0;
			left_q <= 8'h0;
			burst_q <= 1'b0;
		end else if (burst_start) begin
			tick_q <= 32'h0;
			led_q <= 1'b0;
			left_q <= BURST[7:0];
			burst_q <= 1'b1;
		end else if (!active) begin
			tick_q <= 32'h0;
			led_q <= 1'b0;
		end else if (wrap) begin
			tick_q <= 32'h0;
			led_q <= ~led_q;
			// one blink ends when the led goes dark
			if (burst_q && led_q) begin
				left_q <= left_q - 8'h01;
				if (left_q == 8'h01)
					burst_q <= 1'b0;
			end
		end else begin
			tick_q <= tick_q + 32'h1;
		end
	end
endmodule

// File: testbench/nst_far_side.sv
// far-side medium and board fault model for the self-test bench
`timescale 1ns/100ps
module nst_far_side (
	input wire aclk,
	input wire [9:0] cmd,
	output logic [9:0] far
);
	logic [5:0] drop_q = 6'h00;
	// paths, defects and board faults as commanded
	always @(posedge aclk) begin
		far[1:0] <= ~cmd[1:0];
		far[8:2] <= cmd[8:2];
		if (!cmd[9])
			drop_q <= 6'h00;
		else if (drop_q != 6'h3F)
			drop_q <= drop_q + 6'h01;
		far[9] <= drop_q > 6'h14; // link drops part-way
	end
endmodule

// File: testbench/nst_checker_properties.sv
// port checks for the self-test block
`timescale 1ns/100ps
module nst_checker #(
	parameter BLINK_HALF = 3
) (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire link_enable,
	input wire test_ok_indicator,
	input wire error_indicator,
	input wire [8:0] err_indicators,
	input wire irq
);
	reg [7:0] elen_q;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// length of the current error led pulse
	always @(posedge aclk) begin
		if (!aresetn || !error_indicator)
			elen_q <= 8'h00;
		else
			elen_q <= elen_q + 8'h01;
	end
	a_offline_link: assert property (
		(test_ok_indicator || error_indicator) |-> !link_enable)
		else $error("link enabled while a test shows");
	a_ok_no_err: assert property (
		test_ok_indicator |-> !error_indicator && err_indicators == 9'h000)
		else $error("error shown with test ok");
	a_err_held: assert property (
		(|err_indicators) && !s_axi_awvalid |=> $stable(err_indicators))
		else $error("error indicators moved");
	a_err_blink: assert property (
		$fell(error_indicator) && (|err_indicators) |-> elen_q == BLINK_HALF)
		else $error("error blink length wrong");
	a_b_stands: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped early");
	a_r_stands: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("rvalid dropped early");
	a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("awready with bvalid");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready with rvalid");
	c_irq: cover property ($rose(irq));
	c_fail: cover property ($rose(|err_indicators));
	c_offline: cover property ($fell(link_enable));
endmodule
bind nst_self_test nst_checker #(.BLINK_HALF(BLINK_HALF)) nst_checker_i (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.link_enable(link_enable), .test_ok_indicator(test_ok_indicator),
	.error_indicator(error_indicator), .err_indicators(err_indicators),
	.irq(irq));

// File: testbench/tb_top.sv
// self-checking bench for the self-test block
`timescale 1ns/100ps
module tb_top;
	localparam TC = 50;
	localparam BH = 3;
	logic aclk = 1'h0, aresetn = 1'h0, medium_coax_pin = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
	logic [31:0] s_axi_araddr = 32'h0;
	logic [9:0] fault_cmd = 10'h000;
	wire [9:0] far;
	wire [31:0] s_axi_rdata;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, link_enable, test_ok_indicator, error_indicator, irq;
	wire station_conflict_indicator, parameter_error_indicator;
	wire [8:0] err_indicators;
	int n_mismatch = 0, n_compared = 0, cyc = 0;
	nst_self_test #(.TEST_CYCLES(TC), .BLINK_HALF(BH)) nst_self_test_i (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.medium_coax_pin(medium_coax_pin), .fwd_path_ok(far[0]),
		.rev_path_ok(far[1]), .rx_defective(far[2]), .link_lost(far[9]),
		.hw_fault(far[3]), .rom_fail(far[4]), .ram_fail(far[5]),
		.timer_irq_fail(far[6]), .station_conflict(far[7]),
		.param_fault(far[8]), .link_enable(link_enable),
		.test_ok_indicator(test_ok_indicator),
		.error_indicator(error_indicator), .err_indicators(err_indicators),
		.station_conflict_indicator(station_conflict_indicator),
		.parameter_error_indicator(parameter_error_indicator), .irq(irq));
	nst_far_side nst_far_side_i (.aclk(aclk), .cmd(fault_cmd), .far(far));
	initial forever #4 aclk = ~aclk;
	// hang guard
	always @(posedge aclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			n_mismatch = n_mismatch + 1;
			tally_and_finish;
		end
	end
	task tally_and_finish;
		begin
			if (n_mismatch == 0 && n_compared > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		begin
			n_compared = n_compared + 1;
			if (g !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("MISMATCH %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task axi_write(input logic [31:0] a, d, output logic [1:0] r);
		logic aw, w;
		begin
			aw = 0;
			w = 0;
			@(posedge aclk);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			s_axi_bready <= 1'h1;
			while (!(aw && w)) begin
				@(posedge aclk);
				if (s_axi_awvalid && s_axi_awready) aw = 1;
				if (s_axi_wvalid && s_axi_wready) w = 1;
				if (aw) s_axi_awvalid <= 1'h0;
				if (w) s_axi_wvalid <= 1'h0;
			end
			@(posedge aclk);
			while (!s_axi_bvalid) @(posedge aclk);
			r = s_axi_bresp;
			s_axi_bready <= 1'h0;
		end
	endtask
	task axi_read(input logic [31:0] a, output logic [31:0] d,
			output logic [1:0] r);
		begin
			@(posedge aclk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'h1;
			s_axi_rready <= 1'h1;
			@(posedge aclk);
			while (!s_axi_arready) @(posedge aclk);
			s_axi_arvalid <= 1'h0;
			@(posedge aclk);
			while (!s_axi_rvalid) @(posedge aclk);
			d = s_axi_rdata;
			r = s_axi_rresp;
			s_axi_rready <= 1'h0;
		end
	endtask
	task do_reset(input logic coax);
		begin
			@(posedge aclk);
			medium_coax_pin <= coax;
			aresetn <= 1'h0;
			repeat (5) @(posedge aclk);
			aresetn <= 1'h1;
			repeat (4) @(posedge aclk);
		end
	endtask
	task test_regs(input logic coax);
		logic [31:0] d;
		logic [1:0] r;
		begin
			#1;
			chk("link_rst", 32'h1, link_enable);
			axi_read(32'h4, d, r);
			chk("status_rst", {16'h0, coax, 15'h0}, d);
			axi_read(32'h10, d, r);
			chk("far_resp", 32'h2, r);
			axi_write(32'h4, 32'h0, r);
			chk("ro_resp", 32'h2, r);
			axi_write(32'hC, 32'h3, r);
			axi_read(32'hC, d, r);
			chk("mask", 32'h3, d);
		end
	endtask
	task test_pass;
		logic [31:0] d;
		logic [1:0] r;
		logic ok, er, pv;
		int n;
		begin
			ok = 0;
			er = 0;
			pv = 0;
			n = 0;
			axi_write(32'hC, 32'h1, r);
			axi_write(32'h0, 32'h11, r);
			#1;
			chk("link_run", 32'h0, link_enable);
			repeat (TC) begin
				@(posedge aclk);
				ok = ok | test_ok_indicator;
				er = er | error_indicator;
			end
			chk("run_blink", 32'h1, ok);
			while (irq !== 1'h1) begin
				@(posedge aclk);
				n = n + (test_ok_indicator && !pv);
				pv = test_ok_indicator;
				er = er | error_indicator;
			end
			chk("blinks", 32'd20, n);
			chk("err_led", 32'h0, er);
			axi_read(32'h8, d, r);
			chk("stat_pass", 32'h1, d);
			axi_read(32'h8, d, r);
			chk("stat_clr", 32'h0, d);
			axi_write(32'h0, 32'h0, r);
		end
	endtask
	task test_mask;
		logic [31:0] d;
		logic [1:0] r;
		begin
			fault_cmd <= 10'h010;
			axi_write(32'h0, 32'h13, r);
			repeat (TC + 10) @(posedge aclk);
			#1;
			chk("irq_masked", 32'h0, irq);
			axi_write(32'hC, 32'h3, r);
			#1;
			chk("irq_on", 32'h1, irq);
			axi_read(32'h8, d, r);
			#1;
			chk("irq_off", 32'h0, irq);
			fault_cmd <= 10'h000;
			axi_write(32'h0, 32'h0, r);
		end
	endtask
	task fault_case(input logic [1:0] m, input logic [9:0] c,
			input logic [8:0] e, input logic [1:0] x);
		logic [31:0] d;
		logic [1:0] r;
		logic s;
		begin
			s = 0;
			fault_cmd <= c;
			axi_write(32'h0, {27'h0, 3'h4, m}, r);
			while (irq !== 1'h1) @(posedge aclk);
			#1;
			chk("err", e, err_indicators);
			chk("extra", x, {station_conflict_indicator,
				parameter_error_indicator});
			repeat (4 * BH) begin
				@(posedge aclk);
				s = s | error_indicator;
			end
			chk("err_blink", 32'h1, s);
			chk("err_hold", e, err_indicators);
			axi_read(32'h8, d, r);
			chk("stat_fail", 32'h2, d);
			axi_read(32'h4, d, r);
			chk("st_fail", {2'h2, e}, {d[12:11], d[8:0]});
			fault_cmd <= 10'h000;
			axi_write(32'h0, 32'h0, r);
			#1;
			chk("err_clr", 32'h0, err_indicators);
			chk("link_back", 32'h1, link_enable);
		end
	endtask
	task test_ring;
		begin
			fault_case(2'h1, 10'h001, 9'h040, 2'h0);
			fault_case(2'h1, 10'h002, 9'h080, 2'h0);
			fault_case(2'h1, 10'h084, 9'h03F, 2'h0);
			fault_case(2'h1, 10'h008, 9'h100, 2'h0);
			fault_case(2'h1, 10'h200, 9'h100, 2'h0);
			fault_case(2'h2, 10'h008, 9'h1FF, 2'h0);
			fault_case(2'h3, 10'h010, 9'h001, 2'h0);
			fault_case(2'h3, 10'h020, 9'h002, 2'h0);
			fault_case(2'h3, 10'h040, 9'h004, 2'h0);
			fault_case(2'h3, 10'h001, 9'h040, 2'h0);
			fault_case(2'h3, 10'h002, 9'h080, 2'h0);
		end
	endtask
	task test_coax;
		begin
			fault_case(2'h1, 10'h001, 9'h040, 2'h0);
			fault_case(2'h1, 10'h004, 9'h03F, 2'h0);
			fault_case(2'h1, 10'h008, 9'h180, 2'h0);
			fault_case(2'h1, 10'h200, 9'h180, 2'h0);
			fault_case(2'h1, 10'h184, 9'h03F, 2'h3);
			fault_case(2'h2, 10'h008, 9'h1FF, 2'h0);
		end
	endtask
	// main sequence: ring board, then coax board
	initial begin
		do_reset(1'h0);
		test_regs(1'h0);
		test_pass;
		test_mask;
		test_ring;
		do_reset(1'h1);
		test_regs(1'h1);
		test_coax;
		tally_and_finish;
	end
endmodule
